// ---- inc/clkbuf_regs_pkg.sv ----
package clkbuf_regs_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [6:0] OFS_UPPER_OUTPUT_ENABLE = 7'h00;
  localparam logic [6:0] OFS_LOW_OUTPUT_ENABLE = 7'h01;
  localparam logic [6:0] OFS_MID_OUTPUT_ENABLE = 7'h02;
  localparam logic [6:0] OFS_ENABLE_PIN_READBACK = 7'h03;
  localparam logic [6:0] OFS_INTERFACE_SELECT_READBACK = 7'h04;
  localparam logic [6:0] OFS_VENDOR_REVISION_CODE = 7'h05;
  localparam logic [6:0] OFS_PART_IDENTIFIER = 7'h06;
  localparam logic [6:0] OFS_BLOCK_READ_COUNT = 7'h07;
  localparam logic [6:0] OFS_SIDEBAND_OVERRIDE_LOW = 7'h08;
  localparam logic [6:0] OFS_SIDEBAND_OVERRIDE_MID = 7'h09;
  localparam logic [6:0] OFS_SIDEBAND_OVERRIDE_HIGH = 7'h0A;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int UPPER_EN_LSB = 3;
  localparam int UPPER_EN_WIDTH = 4;
  localparam int UPPER_FIRST_OUTPUT = 16;
  localparam int PIN_FIRST_OUTPUT = 5;
  localparam int PIN_COUNT = 8;
  localparam int BLOCK_COUNT_WIDTH = 6;
  localparam int VENDOR_LSB = 0;
  localparam int REVISION_LSB = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0] RST_UPPER_EN = 4'hF;
  localparam logic [7:0] RST_OUTPUT_EN = 8'hFF;
  localparam logic [5:0] RST_BLOCK_COUNT = 6'h08;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;

  // ----------------------------------------
  // register port carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic ack;
    logic refused;
    logic [7:0] rdata;
  } reg_rsp_s;

endpackage : clkbuf_regs_pkg

// ---- rtl/clock_buffer_output_enable_regs.sv ----
// Contract
// - byte 0 bits 3-6 enable outputs 16-19
// - byte 1 enables outputs 0-7, reset ones
// - byte 2 enables outputs 8-15, reset ones
// - byte 3 reads enable pins 5-12 live
// - byte 4 bit 0 reads select pin
// - byte 5 fixed vendor and revision codes
// - byte 6 fixed part identifier code
// - byte 7 block count, resets to eight
// - byte 8 overrides outputs 0-7, reset zero
// - byte 9 overrides outputs 8-15, reset zero
// - byte 10 overrides 16-19, upper bits stored
// - overrides act only with select pin high
// - power good low means low-power mode
// - pin mode: pin low and bit set
// - host sets bit 7 or sends count 1-32; byte 7 stores bits 0-5 only, bit 7 is dropped
// - no register access while power good low
// - select pin chooses side port or pins
module clock_buffer_output_enable_regs
  import clkbuf_regs_pkg::*;
#(
  parameter int NUM_OUTPUTS = 20,
  // arbitrary identity values
  parameter logic [3:0] VENDOR_CODE = 4'hA,
  parameter logic [3:0] REVISION_CODE = 4'h1,
  parameter logic [7:0] PART_CODE = 8'h5A
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // device pins
  input wire logic power_good_input,
  input wire logic sideband_select_pin,
  input wire logic [PIN_COUNT-1:0] oe_pin_n,
  // output register of the three-wire side port
  input wire logic [19:0] three_wire_side_port,
  // register port from the bus engine
  input wire reg_req_s reg_req,
  output reg_rsp_s reg_rsp,
  // register views for the bus engine and outputs
  output logic [5:0] block_count_field,
  output logic low_power_mode,
  output logic [19:0] differential_output_pair
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // the map fixes twenty outputs; nothing else fits the bytes
  if (NUM_OUTPUTS != 20)
  begin : g_bad_count
    $error("NUM_OUTPUTS must be 20");
  end

  // the pin readback is one byte wide
  if (PIN_COUNT != 8)
  begin : g_bad_pins
    $error("PIN_COUNT must be 8");
  end

  // pin-controlled outputs must exist
  if (PIN_FIRST_OUTPUT + PIN_COUNT > NUM_OUTPUTS)
  begin : g_bad_pin_range
    $error("pin range exceeds outputs");
  end

  // pins and the upper byte must not share outputs
  if (PIN_FIRST_OUTPUT + PIN_COUNT > UPPER_FIRST_OUTPUT)
  begin : g_bad_pin_overlap
    $error("pin range overlaps upper outputs");
  end

  // the upper enables must close the output range
  if (UPPER_FIRST_OUTPUT + UPPER_EN_WIDTH != NUM_OUTPUTS)
  begin : g_bad_upper
    $error("upper enables must end at the last output");
  end

  // the upper enable field sits inside one byte
  if (UPPER_EN_LSB + UPPER_EN_WIDTH > 8)
  begin : g_bad_upper_field
    $error("upper enable field exceeds a byte");
  end

  // the count field sits inside one byte
  if (BLOCK_COUNT_WIDTH > 8)
  begin : g_bad_count_field
    $error("block count field exceeds a byte");
  end

  // vendor and revision nibbles must not overlap
  if (REVISION_LSB != VENDOR_LSB + 4)
  begin : g_bad_id_fields
    $error("vendor and revision fields overlap");
  end

  // a zero count would make block reads empty
  if (RST_BLOCK_COUNT == 6'h00)
  begin : g_bad_count_reset
    $error("block count must not reset to zero");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    // output enables, registers win only in pin mode
    logic [3:0] upper_en;
    logic [7:0] low_en;
    logic [7:0] mid_en;
    logic [5:0] block_count;
    logic [1:0] block_spare;
    // override masks, kept through low-power mode
    logic [7:0] override_low;
    logic [7:0] override_mid;
    logic [7:0] override_high;
    // answer to the last request
    reg_rsp_s rsp;
    // registered so the pairs never see a decode glitch
    logic [19:0] out_en;
  } state_s;

  state_s state;
  state_s next_state;
  logic [19:0] reg_enable;
  logic [19:0] side_override;
  logic [19:0] pin_enable;
  logic [19:0] want_enable;
  logic [19:0] pin_mode_enable;
  logic [19:0] side_mode_enable;
  logic [7:0] read_value;
  logic access_refused;
  logic read_hit;

  // ----------------------------------------
  // per-output views
  // ----------------------------------------
  assign reg_enable = {state.upper_en, state.mid_en, state.low_en};
  assign side_override = {state.override_high[3:0], state.override_mid, state.override_low};

  genvar i;
  for (i = 0; i < 20; i++)
  begin : g_out
    if (i >= PIN_FIRST_OUTPUT && i < PIN_FIRST_OUTPUT + PIN_COUNT)
    begin : g_pin
      // pin low means enabled
      assign pin_enable[i] = ~oe_pin_n[i - PIN_FIRST_OUTPUT];
    end
    else
    begin : g_nopin
      // outputs without a pin follow their register bit only
      assign pin_enable[i] = 1'b1;
    end
    // pin mode: register bit 0 disables whatever the pin says
    assign pin_mode_enable[i] = pin_enable[i] & reg_enable[i];
    // side mode: a set override bit keeps the output on
    assign side_mode_enable[i] = three_wire_side_port[i] | side_override[i];
    assign want_enable[i] = sideband_select_pin ? side_mode_enable[i] : pin_mode_enable[i];
  end

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  always_comb
  begin
    read_value = 8'h00;
    unique case (reg_req.addr)
      OFS_UPPER_OUTPUT_ENABLE:
        read_value[UPPER_EN_LSB +: UPPER_EN_WIDTH] = state.upper_en;
      OFS_LOW_OUTPUT_ENABLE:
        read_value = state.low_en;
      OFS_MID_OUTPUT_ENABLE:
        read_value = state.mid_en;
      // raw pin levels; pins are taken as synchronous
      OFS_ENABLE_PIN_READBACK:
        read_value = oe_pin_n;
      OFS_INTERFACE_SELECT_READBACK:
        read_value[0] = sideband_select_pin;
      // fixed identity bytes
      OFS_VENDOR_REVISION_CODE:
      begin
        read_value[VENDOR_LSB +: 4] = VENDOR_CODE;
        read_value[REVISION_LSB +: 4] = REVISION_CODE;
      end
      OFS_PART_IDENTIFIER:
        read_value = PART_CODE;
      OFS_BLOCK_READ_COUNT:
        read_value = {2'h0, state.block_count};
      OFS_SIDEBAND_OVERRIDE_LOW:
        read_value = state.override_low;
      OFS_SIDEBAND_OVERRIDE_MID:
        read_value = state.override_mid;
      OFS_SIDEBAND_OVERRIDE_HIGH:
        read_value = state.override_high;
      default:
        read_value = 8'h00;
    endcase
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // refusal leaves every register as it was
  assign access_refused = reg_req.valid & ~power_good_input;
  assign read_hit = reg_req.valid & power_good_input & ~reg_req.write;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.rsp.ack = 1'b0;
    next_state.rsp.refused = 1'b0;
    if (reg_req.valid)
    begin
      if (access_refused)
      begin
        // bus side is powered down; refuse and keep contents
        next_state.rsp.refused = 1'b1;
      end
      else
      begin
        // read-only and unmapped bytes still acknowledge
        next_state.rsp.ack = 1'b1;
        if (read_hit)
        begin
          next_state.rsp.rdata = read_value;
        end
        else
        begin
          unique case (reg_req.addr)
            OFS_UPPER_OUTPUT_ENABLE:
              next_state.upper_en = reg_req.wdata[UPPER_EN_LSB +: UPPER_EN_WIDTH];
            OFS_LOW_OUTPUT_ENABLE:
              next_state.low_en = reg_req.wdata;
            OFS_MID_OUTPUT_ENABLE:
              next_state.mid_en = reg_req.wdata;
            OFS_BLOCK_READ_COUNT:
              next_state.block_count = reg_req.wdata[BLOCK_COUNT_WIDTH-1:0];
            OFS_SIDEBAND_OVERRIDE_LOW:
              next_state.override_low = reg_req.wdata;
            OFS_SIDEBAND_OVERRIDE_MID:
              next_state.override_mid = reg_req.wdata;
            OFS_SIDEBAND_OVERRIDE_HIGH:
              next_state.override_high = reg_req.wdata;
            OFS_ENABLE_PIN_READBACK,
            OFS_INTERFACE_SELECT_READBACK,
            OFS_VENDOR_REVISION_CODE,
            OFS_PART_IDENTIFIER:
            begin
              // acknowledged only; these bytes are pins or constants
              next_state.block_spare = state.block_spare;
            end
            default:
              next_state.block_spare = state.block_spare;
          endcase
        end
      end
    end
    // low-power mode forces every pair low
    next_state.out_en = power_good_input ? want_enable : 20'h00000;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state.upper_en <= RST_UPPER_EN;
      state.low_en <= RST_OUTPUT_EN;
      state.mid_en <= RST_OUTPUT_EN;
      state.block_count <= RST_BLOCK_COUNT;
      state.block_spare <= 2'h0;
      state.override_low <= RST_OVERRIDE;
      state.override_mid <= RST_OVERRIDE;
      state.override_high <= RST_OVERRIDE;
      state.rsp <= '0;
      state.out_en <= 20'h00000;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rsp = state.rsp;
  // the bus engine gets only the six-bit count; the byte-mode bit is not kept
  assign block_count_field = state.block_count;
  // combinational so the engine sees power loss at once
  assign low_power_mode = ~power_good_input;
  assign differential_output_pair = state.out_en;

endmodule : clock_buffer_output_enable_regs

// ---- sim/reg_host.sv ----
module reg_host
  import clkbuf_regs_pkg::*;
(
  // bus side
  input wire logic core_clk,
  input wire reg_rsp_s rsp,
  output reg_req_s req
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // one byte per request, single-byte access only
  // --------
  initial req = '0;
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
    output logic [9:0] r);
    begin
      req <= '{1'b1, wr, a, d};
      @(posedge core_clk);
      req <= '0;
      @(negedge core_clk);
      r = {rsp.ack, rsp.refused, rsp.rdata};
      @(posedge core_clk);
    end
  endtask : xfer
endmodule : reg_host

// ---- sim/clkbuf_regs_monitor.sv ----
module clkbuf_regs_monitor
  import clkbuf_regs_pkg::*;
(
  // watched ports
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic power_good_input,
  input wire logic sideband_select_pin,
  input wire logic [PIN_COUNT-1:0] oe_pin_n,
  input wire logic [19:0] three_wire_side_port,
  input wire reg_req_s reg_req,
  input wire reg_rsp_s reg_rsp,
  input wire logic [5:0] block_count_field,
  input wire logic low_power_mode,
  input wire logic [19:0] differential_output_pair
);
  // --------
  // port relations
  // --------
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_refuse_low_power: assert property (reg_req.valid && !power_good_input
    |=> reg_rsp.refused && !reg_rsp.ack) else $error("request not refused");
  chk_ack_active: assert property (reg_req.valid && power_good_input
    |=> reg_rsp.ack && !reg_rsp.refused) else $error("request not acked");
  chk_mode_follows: assert property (low_power_mode == !power_good_input)
    else $error("low power mode wrong");
  chk_outputs_off: assert property (!power_good_input
    |=> differential_output_pair == 20'h00000) else $error("outputs run in low power");
  chk_side_enables: assert property (power_good_input && sideband_select_pin
    |=> (differential_output_pair & $past(three_wire_side_port)) == $past(three_wire_side_port))
    else $error("side port enable lost");
  chk_pin_disables: assert property (power_good_input && !sideband_select_pin
    |=> (differential_output_pair[12:5] & $past(oe_pin_n)) == 8'h00)
    else $error("pin high but output runs");
  chk_count_write: assert property (reg_req.valid && reg_req.write && power_good_input
    && reg_req.addr == OFS_BLOCK_READ_COUNT
    |=> block_count_field == $past(reg_req.wdata[5:0])) else $error("count not written");
  chk_pin_readback: assert property (reg_req.valid && !reg_req.write && power_good_input
    && reg_req.addr == OFS_ENABLE_PIN_READBACK
    |=> reg_rsp.rdata == $past(oe_pin_n)) else $error("pin readback wrong");
endmodule : clkbuf_regs_monitor

bind clock_buffer_output_enable_regs clkbuf_regs_monitor u_mon (.core_clk(core_clk),
  .resetn(resetn), .power_good_input(power_good_input),
  .sideband_select_pin(sideband_select_pin), .oe_pin_n(oe_pin_n),
  .three_wire_side_port(three_wire_side_port), .reg_req(reg_req), .reg_rsp(reg_rsp),
  .block_count_field(block_count_field), .low_power_mode(low_power_mode),
  .differential_output_pair(differential_output_pair));

// ---- sim/test_clock_buffer_output_enable_regs.sv ----
module test_clock_buffer_output_enable_regs
  import clkbuf_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, resetn = 0, power_good_input = 1, sideband_select_pin = 0;
  logic [7:0] oe_pin_n = 8'h0F;
  logic [19:0] three_wire_side_port = 20'h00F0F;
  reg_req_s reg_req;
  reg_rsp_s reg_rsp;
  logic [5:0] block_count_field;
  logic low_power_mode;
  logic [19:0] differential_output_pair;
  logic [9:0] r;
  int bad_count = 0, comparisons = 0;
  logic [7:0] rst_tab [11] = '{8'h78, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h1A, 8'h5A, 8'h08,
    8'h00, 8'h00, 8'h00};
  logic [7:0] wr_tab [12] = '{8'h20, 8'hA5, 8'hA5, 8'h0F, 8'h00, 8'h1A, 8'h5A, 8'h25,
    8'hA5, 8'hA5, 8'hA5, 8'h00};
  logic [7:0] pins_tab [2] = '{8'h3C, 8'h00};
  clock_buffer_output_enable_regs u_dut (.core_clk(core_clk), .resetn(resetn),
    .power_good_input(power_good_input), .sideband_select_pin(sideband_select_pin),
    .oe_pin_n(oe_pin_n), .three_wire_side_port(three_wire_side_port), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .block_count_field(block_count_field),
    .low_power_mode(low_power_mode), .differential_output_pair(differential_output_pair));
  reg_host u_host (.core_clk(core_clk), .rsp(reg_rsp), .req(reg_req));
  // --------
  // scenarios
  // --------
  initial forever #50 core_clk = ~core_clk;
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    begin
      comparisons++;
      if (seen !== want)
      begin
        bad_count++;
        $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
    end
  endtask : check
  task automatic results();
    begin
      $display("mismatches %0d of %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask : results
  task automatic t_regs();
    begin
      check(block_count_field, 6'h08);
      for (int i = 0; i < 11; i++)
      begin
        u_host.xfer(1'b0, 7'(i), 8'h00, r);
        check(r, {2'b10, rst_tab[i]});
      end
      for (int i = 0; i < 12; i++)
        u_host.xfer(1'b1, 7'(i), 8'hA5, r);
      for (int i = 0; i < 12; i++)
      begin
        u_host.xfer(1'b0, 7'(i), 8'h00, r);
        check(r, {2'b10, wr_tab[i]});
      end
      check(block_count_field, 6'h25);
    end
  endtask : t_regs
  task automatic t_pins();
    logic [19:0] e;
    begin
      for (int k = 0; k < 2; k++)
      begin
        oe_pin_n <= pins_tab[k];
        repeat (2) @(posedge core_clk);
        e = 20'h4A5A5;
        e[12:5] = e[12:5] & ~pins_tab[k];
        check(differential_output_pair, e);
        u_host.xfer(1'b0, OFS_ENABLE_PIN_READBACK, 8'h00, r);
        check(r[7:0], pins_tab[k]);
      end
    end
  endtask : t_pins
  task automatic t_side();
    begin
      sideband_select_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(differential_output_pair, three_wire_side_port | 20'h5A5A5);
      u_host.xfer(1'b0, OFS_INTERFACE_SELECT_READBACK, 8'h00, r);
      check(r[7:0], 8'h01);
    end
  endtask : t_side
  task automatic t_power();
    begin
      power_good_input <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(low_power_mode, 1'b1);
      check(differential_output_pair, 20'h00000);
      u_host.xfer(1'b1, OFS_LOW_OUTPUT_ENABLE, 8'h00, r);
      check(r[9:8], 2'b01);
      power_good_input <= 1'b1;
      @(posedge core_clk);
      u_host.xfer(1'b0, OFS_LOW_OUTPUT_ENABLE, 8'h00, r);
      check(r, {2'b10, 8'hA5});
    end
  endtask : t_power
  // generous against some 90 cycles of traffic
  initial
  begin
    repeat (2000) @(posedge core_clk);
    bad_count++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_pins();
    t_side();
    t_power();
    results();
  end
endmodule : test_clock_buffer_output_enable_regs
